// ==== hdl/cfgdbg_loader.sv ====
// Option byte loader, lock gate and debug pin and clock control
`timescale 1ns/1ns
module cfgdbg_loader
  import cfgdbg_pkg::*;
#(
  parameter int PWM_CH = 6
) (
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic [OPT_W-1:0]  optionNv,
  input  wire logic              sfrWrEn,
  input  wire logic [OPT_W-1:0]  sfrWData,
  input  wire logic              oscOffReq,
  input  wire logic              oscOnReq,
  input  wire logic              powerDown,
  input  wire logic              cpuHalted,
  input  wire logic              dbgAccReq,
  input  wire logic [PWM_CH-1:0] pwmIn,
  input  wire logic [PWM_CH-1:0] pwmPinOutEn,
  input  wire logic              rstPinIn,
  input  wire logic              pin00In,
  input  wire logic              pin01In,
  input  wire logic              gpio00Out,
  input  wire logic              gpio00OeN,
  input  wire logic              gpio01Out,
  input  wire logic              gpio01OeN,
  input  wire logic              dbgDataOut,
  input  wire logic              dbgDataOeN,
  input  cfgdbg_req_t            extReq,
  input  cfgdbg_req_t            iapReq,
  input  wire logic [OPT_W-1:0]  flashRData,
  output logic [OPT_W-1:0]       chipCtrl_ff,
  output logic                   coreSwReset_ff,
  output logic                   debugActive_ff,
  output logic                   fastOscEn_ff,
  output logic                   dbgAccGrant_ff,
  output logic                   dbgAccReject_ff,
  output logic [PWM_CH-1:0]      pwmPinOut_ff,
  output logic [PWM_CH-1:0]      pwmPinOeN_ff,
  output logic                   extResetReq_ff,
  output logic                   p12In_ff,
  output logic                   pin00Out_ff,
  output logic                   pin00OeN_ff,
  output logic                   pin01Out_ff,
  output logic                   pin01OeN_ff,
  output logic                   gpio00In_ff,
  output logic                   gpio01In_ff,
  output logic                   dbgDataIn_ff,
  output logic                   dbgClkIn_ff,
  output logic                   extAck_ff,
  output logic                   extOk_ff,
  output logic [OPT_W-1:0]       extRData_ff,
  output logic                   iapAck_ff,
  output logic [OPT_W-1:0]       iapRData_ff,
  output logic [ADDR_W-1:0]      flashAddr_ff,
  output logic                   flashRdEn_ff,
  output logic                   flashPgm_ff,
  output logic [OPT_W-1:0]       flashWData_ff,
  output logic                   flashEraseAll_ff,
  output logic                   optPgm_ff,
  output logic [OPT_W-1:0]       optWData_ff
);

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [2:0] pinMeta_ff;
  logic [2:0] pinSync_ff;
  logic [2:0] nxt_pinMeta;
  logic [2:0] nxt_pinSync;

  always_comb begin
    nxt_pinMeta = {rstPinIn, pin01In, pin00In};
    nxt_pinSync = pinMeta_ff;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pinMeta_ff <= 3'h7;
      pinSync_ff <= 3'h7;
    end else begin
      pinMeta_ff <= nxt_pinMeta;
      pinSync_ff <= nxt_pinSync;
    end
  end

  // ------------------------------------------------------------
  // Option reload and chip control register
  // ------------------------------------------------------------
  cfgdbg_opt_t opt_ff;
  cfgdbg_opt_t nxt_opt;
  logic        loadPend_ff;
  logic        nxt_loadPend;
  logic [7:0]  nxt_chipCtrl;
  logic        nxt_coreSwReset;
  logic        nxt_debugActive;
  logic        iapFail;

  always_comb begin
    nxt_opt         = opt_ff;
    nxt_loadPend    = 1'b0;
    nxt_chipCtrl    = chipCtrl_ff;
    nxt_coreSwReset = 1'b0;
    if (loadPend_ff) begin
      nxt_opt.bootApp  = optionNv[OPT_BOOT];
      nxt_opt.pwmFloat = optionNv[OPT_PWMFLT];
      nxt_opt.dbgEnN   = optionNv[OPT_DBGEN];
      nxt_opt.rstPinEn = optionNv[OPT_RSTPIN];
      nxt_opt.unlocked = optionNv[OPT_LOCK];
      nxt_chipCtrl[CTL_BOOT] = optionNv[OPT_BOOT];
    end else if (sfrWrEn) begin
      nxt_chipCtrl = (chipCtrl_ff & ~CTL_WMASK) | (sfrWData & CTL_WMASK);
      // Fail flag only clears on a written zero
      if (!sfrWData[CTL_FAIL]) begin
        nxt_chipCtrl[CTL_FAIL] = 1'b0;
      end
      nxt_coreSwReset = sfrWData[CTL_SOFTWARE_RESET_TRIGGER];
    end
    // Hardware set wins over a software clear
    if (iapFail) begin
      nxt_chipCtrl[CTL_FAIL] = 1'b1;
    end
    nxt_debugActive = !nxt_opt.dbgEnN && nxt_opt.unlocked;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      opt_ff         <= cfgdbg_opt_t'(5'h1F);
      loadPend_ff    <= 1'b1;
      chipCtrl_ff    <= CTL_RESET;
      coreSwReset_ff <= 1'b0;
      debugActive_ff <= 1'b0;
    end else begin
      opt_ff         <= nxt_opt;
      loadPend_ff    <= nxt_loadPend;
      chipCtrl_ff    <= nxt_chipCtrl;
      coreSwReset_ff <= nxt_coreSwReset;
      debugActive_ff <= nxt_debugActive;
    end
  end

  // ------------------------------------------------------------
  // Fast oscillator and debugger access gate
  // ------------------------------------------------------------
  logic nxt_fastOscEn;
  logic nxt_dbgAccGrant;
  logic nxt_dbgAccReject;

  always_comb begin
    nxt_fastOscEn = fastOscEn_ff;
    if (oscOnReq) begin
      nxt_fastOscEn = 1'b1;
    end else if (oscOffReq && !debugActive_ff) begin
      nxt_fastOscEn = 1'b0;
    end
    if (debugActive_ff) begin
      nxt_fastOscEn = 1'b1;
    end
    nxt_dbgAccGrant  = dbgAccReq && debugActive_ff && cpuHalted && !powerDown;
    nxt_dbgAccReject = dbgAccReq && !nxt_dbgAccGrant;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fastOscEn_ff    <= 1'b1;
      dbgAccGrant_ff  <= 1'b0;
      dbgAccReject_ff <= 1'b0;
    end else begin
      fastOscEn_ff    <= nxt_fastOscEn;
      dbgAccGrant_ff  <= nxt_dbgAccGrant;
      dbgAccReject_ff <= nxt_dbgAccReject;
    end
  end

  // ------------------------------------------------------------
  // Shared pins and PWM outputs
  // ------------------------------------------------------------
  logic [PWM_CH-1:0] nxt_pwmPinOut;
  logic [PWM_CH-1:0] nxt_pwmPinOeN;
  logic              haltFloat;

  assign haltFloat = debugActive_ff && cpuHalted && opt_ff.pwmFloat;

  genvar ch;
  generate
    for (ch = 0; ch < PWM_CH; ch++) begin : gPwm
      always_comb begin
        nxt_pwmPinOut[ch] = pwmIn[ch];
        nxt_pwmPinOeN[ch] = !pwmPinOutEn[ch] || haltFloat;
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pwmPinOut_ff <= '0;
      pwmPinOeN_ff <= '1;
    end else begin
      pwmPinOut_ff <= nxt_pwmPinOut;
      pwmPinOeN_ff <= nxt_pwmPinOeN;
    end
  end

  logic nxt_extResetReq;
  logic nxt_p12In;
  logic nxt_pin00Out;
  logic nxt_pin00OeN;
  logic nxt_pin01OeN;
  logic nxt_gpio00In;
  logic nxt_gpio01In;
  logic nxt_dbgDataIn;
  logic nxt_dbgClkIn;

  always_comb begin
    nxt_extResetReq = opt_ff.rstPinEn && !pinSync_ff[2];
    nxt_p12In       = opt_ff.rstPinEn ? 1'b1 : pinSync_ff[2];
    if (debugActive_ff) begin
      nxt_pin00Out  = dbgDataOut;
      nxt_pin00OeN  = dbgDataOeN;
      nxt_pin01OeN  = 1'b1;
      nxt_gpio00In  = 1'b1;
      nxt_gpio01In  = 1'b1;
      nxt_dbgDataIn = pinSync_ff[0];
      nxt_dbgClkIn  = pinSync_ff[1];
    end else begin
      nxt_pin00Out  = gpio00Out;
      nxt_pin00OeN  = gpio00OeN;
      nxt_pin01OeN  = gpio01OeN;
      nxt_gpio00In  = pinSync_ff[0];
      nxt_gpio01In  = pinSync_ff[1];
      nxt_dbgDataIn = 1'b1;
      nxt_dbgClkIn  = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      extResetReq_ff <= 1'b0;
      p12In_ff       <= 1'b1;
      pin00Out_ff    <= 1'b1;
      pin00OeN_ff    <= 1'b1;
      pin01Out_ff    <= 1'b1;
      pin01OeN_ff    <= 1'b1;
      gpio00In_ff    <= 1'b1;
      gpio01In_ff    <= 1'b1;
      dbgDataIn_ff   <= 1'b1;
      dbgClkIn_ff    <= 1'b0;
    end else begin
      extResetReq_ff <= nxt_extResetReq;
      p12In_ff       <= nxt_p12In;
      pin00Out_ff    <= nxt_pin00Out;
      pin00OeN_ff    <= nxt_pin00OeN;
      pin01Out_ff    <= gpio01Out;
      pin01OeN_ff    <= nxt_pin01OeN;
      gpio00In_ff    <= nxt_gpio00In;
      gpio01In_ff    <= nxt_gpio01In;
      dbgDataIn_ff   <= nxt_dbgDataIn;
      dbgClkIn_ff    <= nxt_dbgClkIn;
    end
  end

  // ------------------------------------------------------------
  // Flash and option access sequencer
  // ------------------------------------------------------------
  cfgdbg_state_t     state_ff;
  cfgdbg_state_t     nxt_state;
  logic              fromExt_ff;
  logic              nxt_fromExt;
  cfgdbg_cmd_t       cmd_ff;
  cfgdbg_cmd_t       nxt_cmd;
  logic              nxt_extAck;
  logic              nxt_extOk;
  logic [OPT_W-1:0]  nxt_extRData;
  logic              nxt_iapAck;
  logic [OPT_W-1:0]  nxt_iapRData;
  logic [ADDR_W-1:0] nxt_flashAddr;
  logic              nxt_flashRdEn;
  logic              nxt_flashPgm;
  logic [OPT_W-1:0]  nxt_flashWData;
  logic              nxt_flashEraseAll;
  logic              nxt_optPgm;
  logic [OPT_W-1:0]  nxt_optWData;
  logic              locked;
  cfgdbg_req_t       req;

  // Lock follows the live option cells so a chip erase unlocks at once
  assign locked = !optionNv[OPT_LOCK];
  assign req    = extReq.req ? extReq : iapReq;

  always_comb begin
    nxt_state         = state_ff;
    nxt_fromExt       = fromExt_ff;
    nxt_cmd           = cmd_ff;
    nxt_extAck        = 1'b0;
    nxt_extOk         = extOk_ff;
    nxt_extRData      = extRData_ff;
    nxt_iapAck        = 1'b0;
    nxt_iapRData      = iapRData_ff;
    nxt_flashAddr     = flashAddr_ff;
    nxt_flashRdEn     = 1'b0;
    nxt_flashPgm      = 1'b0;
    nxt_flashWData    = flashWData_ff;
    nxt_flashEraseAll = 1'b0;
    nxt_optPgm        = 1'b0;
    nxt_optWData      = optWData_ff;
    iapFail           = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (extReq.req || iapReq.req) begin
          nxt_fromExt   = extReq.req;
          nxt_cmd       = req.cmd;
          nxt_flashAddr = req.addr;
          nxt_state     = ST_WAIT;
          nxt_extOk     = 1'b1;
          if (!extReq.req && !chipCtrl_ff[CTL_SPEN]) begin
            iapFail   = 1'b1;
            nxt_state = ST_DONE;
            nxt_iapAck = 1'b1;
          end else begin
            case (req.cmd)
              CMD_RD_FLASH: begin
                nxt_flashRdEn = 1'b1;
              end
              CMD_PG_FLASH: begin
                nxt_flashPgm   = !(extReq.req && locked);
                nxt_flashWData = req.data;
                nxt_extOk      = !locked;
              end
              CMD_PG_OPT: begin
                // no single option write from the external path when locked
                nxt_optPgm   = !(extReq.req && locked);
                nxt_optWData = optionNv & (req.data | ~OPT_USED);
                nxt_extOk    = !locked;
              end
              CMD_CHIP_ERASE: begin
                nxt_flashEraseAll = 1'b1;
                nxt_optPgm        = 1'b1;
                nxt_optWData      = OPT_ERASED;
              end
              default: begin
                nxt_extOk = 1'b1;
              end
            endcase
          end
        end
      end
      ST_WAIT: begin
        nxt_state = ST_DONE;
        if (fromExt_ff) begin
          nxt_extAck = 1'b1;
          if (cmd_ff == CMD_RD_FLASH) begin
            nxt_extRData = locked ? FLASH_BLANK : flashRData;
          end else if (cmd_ff == CMD_RD_OPT) begin
            nxt_extRData = optionNv;
          end
        end else begin
          nxt_iapAck = 1'b1;
          if (cmd_ff == CMD_RD_FLASH) begin
            nxt_iapRData = flashRData;
          end else if (cmd_ff == CMD_RD_OPT) begin
            nxt_iapRData = optionNv;
          end
        end
      end
      ST_DONE: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_ff         <= ST_IDLE;
      fromExt_ff       <= 1'b0;
      cmd_ff           <= CMD_RD_FLASH;
      extAck_ff        <= 1'b0;
      extOk_ff         <= 1'b0;
      extRData_ff      <= FLASH_BLANK;
      iapAck_ff        <= 1'b0;
      iapRData_ff      <= FLASH_BLANK;
      flashAddr_ff     <= '0;
      flashRdEn_ff     <= 1'b0;
      flashPgm_ff      <= 1'b0;
      flashWData_ff    <= FLASH_BLANK;
      flashEraseAll_ff <= 1'b0;
      optPgm_ff        <= 1'b0;
      optWData_ff      <= OPT_ERASED;
    end else begin
      state_ff         <= nxt_state;
      fromExt_ff       <= nxt_fromExt;
      cmd_ff           <= nxt_cmd;
      extAck_ff        <= nxt_extAck;
      extOk_ff         <= nxt_extOk;
      extRData_ff      <= nxt_extRData;
      iapAck_ff        <= nxt_iapAck;
      iapRData_ff      <= nxt_iapRData;
      flashAddr_ff     <= nxt_flashAddr;
      flashRdEn_ff     <= nxt_flashRdEn;
      flashPgm_ff      <= nxt_flashPgm;
      flashWData_ff    <= nxt_flashWData;
      flashEraseAll_ff <= nxt_flashEraseAll;
      optPgm_ff        <= nxt_optPgm;
      optWData_ff      <= nxt_optWData;
    end
  end

endmodule : cfgdbg_loader

// ==== hdl/cfgdbg_pkg.sv ====
// Option byte layout, commands, states and reset values of the config loader
// Functional notes
// - In debug mode the fast oscillator stays on; switch-off requests are ignored.
// - Power-down during debug mode leaves the fast oscillator enabled.
// - Debugger accesses are accepted only while the core is halted.
// - On debug halt, PWM pins float if option bit 5 is 1, else run.
// - PWM floating applies only to channels whose pin output enable is 1.
// - Debug is active only with debug-enable option 0 and lock option 1.
// - Non-software resets boot application area if bit 7 is 1, else loader.
// - Software reset does not reload options; software boot choice survives it.
// - Option bit 2 at 1 makes the shared pin reset; 0 makes plain input.
// - With lock bit 0, external flash reads return all-ones bytes.
// - Locked chip rejects flash programming from the external paths.
// - Option byte always readable; locked, not programmable on its own from the external path.
// - Only whole-chip erase clears lock, erasing flash and all options.
// - Lock state never affects self-programming by software on the device.
// - After reset, options with run-time copies load into control bits.
// - With debug active, debug data and clock pins serve only the link.
package cfgdbg_pkg;
  localparam int         OPT_W       = 8;
  localparam int         ADDR_W      = 16;
  localparam int         OPT_BOOT    = 7;
  localparam int         OPT_PWMFLT  = 5;
  localparam int         OPT_DBGEN   = 4;
  localparam int         OPT_RSTPIN  = 2;
  localparam int         OPT_LOCK    = 1;
  localparam logic [7:0] OPT_ERASED  = 8'hFF;
  localparam logic [7:0] OPT_USED    = 8'hB6;
  localparam logic [7:0] FLASH_BLANK = 8'hFF;
  localparam int         CTL_SOFTWARE_RESET_TRIGGER   = 7;
  localparam int         CTL_FAIL    = 6;
  localparam int         CTL_BOOT    = 1;
  localparam int         CTL_SPEN    = 0;
  localparam logic [7:0] CTL_RESET   = 8'h00;
  localparam logic [7:0] CTL_WMASK   = 8'h03;

  typedef enum logic [2:0] {
    CMD_RD_FLASH   = 3'h0,
    CMD_PG_FLASH   = 3'h1,
    CMD_RD_OPT     = 3'h2,
    CMD_PG_OPT     = 3'h3,
    CMD_CHIP_ERASE = 3'h4
  } cfgdbg_cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_DONE = 3'b100
  } cfgdbg_state_t;

  typedef struct packed {
    logic              req;
    cfgdbg_cmd_t       cmd;
    logic [ADDR_W-1:0] addr;
    logic [OPT_W-1:0]  data;
  } cfgdbg_req_t;

  typedef struct packed {
    logic bootApp;
    logic pwmFloat;
    logic dbgEnN;
    logic rstPinEn;
    logic unlocked;
  } cfgdbg_opt_t;
endpackage : cfgdbg_pkg

// ==== tb/cfgdbg_loader_monitor.sv ====
// Port checker for the option byte loader
`timescale 1ns/1ns
module cfgdbg_loader_monitor
  import cfgdbg_pkg::*;
#(
  parameter int PWM_CH = 6
) (
  input wire logic              clk_sys,
  input wire logic              rst,
  input wire logic [OPT_W-1:0]  optionNv,
  input wire logic              sfrWrEn,
  input wire logic [OPT_W-1:0]  sfrWData,
  input wire logic              oscOffReq,
  input wire logic              powerDown,
  input wire logic              cpuHalted,
  input wire logic              dbgAccReq,
  input wire logic [PWM_CH-1:0] pwmPinOutEn,
  input cfgdbg_req_t            extReq,
  input cfgdbg_req_t            iapReq,
  input wire logic [OPT_W-1:0]  chipCtrl_ff,
  input wire logic              coreSwReset_ff,
  input wire logic              debugActive_ff,
  input wire logic              fastOscEn_ff,
  input wire logic              dbgAccGrant_ff,
  input wire logic              dbgAccReject_ff,
  input wire logic [PWM_CH-1:0] pwmPinOeN_ff,
  input wire logic              extAck_ff,
  input wire logic              extOk_ff,
  input wire logic [OPT_W-1:0]  extRData_ff,
  input wire logic              flashPgm_ff,
  input wire logic [OPT_W-1:0]  flashWData_ff,
  input wire logic              flashEraseAll_ff,
  input wire logic              optPgm_ff,
  input wire logic [OPT_W-1:0]  optWData_ff
);
  default clocking mcb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  chk_osc_kept: assert property (
    debugActive_ff && (oscOffReq || powerDown) |=> fastOscEn_ff)
    else $error("oscillator stopped in debug");
  chk_grant_halt: assert property (
    dbgAccReq && debugActive_ff && cpuHalted && !powerDown |=> dbgAccGrant_ff && !dbgAccReject_ff)
    else $error("halted access not granted");
  chk_reject_run: assert property (
    dbgAccReq && !cpuHalted |=> dbgAccReject_ff && !dbgAccGrant_ff)
    else $error("running access not refused");
  chk_pwm_run: assert property (
    !$past(rst) && !$past(cpuHalted) |-> pwmPinOeN_ff == ~$past(pwmPinOutEn))
    else $error("pwm drive wrong while running");
  chk_lock_blank: assert property (
    $rose(extReq.req) && extReq.cmd == CMD_RD_FLASH && !optionNv[OPT_LOCK]
    |-> ##2 extAck_ff && extRData_ff == FLASH_BLANK)
    else $error("locked read not blank");
  chk_lock_noprog: assert property (
    $rose(extReq.req) && !optionNv[OPT_LOCK] && extReq.cmd inside {CMD_PG_FLASH, CMD_PG_OPT}
    |-> ##1 !(flashPgm_ff || optPgm_ff) [*2] ##0 extAck_ff && !extOk_ff)
    else $error("locked program performed");
  chk_erase_all: assert property (
    $rose(extReq.req) && extReq.cmd == CMD_CHIP_ERASE
    |-> ##1 flashEraseAll_ff && optPgm_ff && optWData_ff == OPT_ERASED ##1 extAck_ff)
    else $error("chip erase incomplete");
  chk_iap_free: assert property (
    $rose(iapReq.req) && iapReq.cmd == CMD_PG_FLASH && chipCtrl_ff[CTL_SPEN] && !extReq.req
    |=> flashPgm_ff && flashWData_ff == $past(iapReq.data))
    else $error("self program blocked");
  chk_boot_load: assert property (
    $past(rst) && !rst |=> chipCtrl_ff[CTL_BOOT] == optionNv[OPT_BOOT])
    else $error("boot bit not loaded");
  chk_software_reset_trigger_keep: assert property (
    coreSwReset_ff && !sfrWrEn |=> $stable(chipCtrl_ff[CTL_BOOT]) && $stable(debugActive_ff))
    else $error("software reset reloaded options");
  chk_ctrl_write: assert property (
    sfrWrEn && !$past(rst) |=> (chipCtrl_ff & CTL_WMASK) == ($past(sfrWData) & CTL_WMASK)
    && coreSwReset_ff == $past(sfrWData[CTL_SOFTWARE_RESET_TRIGGER]))
    else $error("control write lost");
endmodule : cfgdbg_loader_monitor

bind cfgdbg_loader cfgdbg_loader_monitor #(.PWM_CH(PWM_CH)) u_mon (.*);

// ==== tb/cfgdbg_flash_model.sv ====
// Flash array and option cells behind the loader
`timescale 1ns/1ns
module cfgdbg_flash_model
  import cfgdbg_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic [ADDR_W-1:0] flashAddr_ff,
  input  wire logic              flashRdEn_ff,
  input  wire logic              flashPgm_ff,
  input  wire logic [OPT_W-1:0]  flashWData_ff,
  input  wire logic              flashEraseAll_ff,
  input  wire logic              optPgm_ff,
  input  wire logic [OPT_W-1:0]  optWData_ff,
  input  wire logic              optLoad,
  input  wire logic [OPT_W-1:0]  optSet,
  output logic [OPT_W-1:0]       optionNv,
  output logic [OPT_W-1:0]       flashRData
);
  logic [OPT_W-1:0] mem [16];
  logic [OPT_W-1:0] junk;

  // Data stands while the strobe is high, changing garbage otherwise
  assign flashRData = flashRdEn_ff ? mem[flashAddr_ff[3:0]] : junk;

  initial begin
    junk = 8'h5A;
    foreach (mem[i]) begin
      mem[i] = 8'hA5 ^ 8'(i);
    end
  end

  always @(posedge clk_sys) begin
    junk <= ~junk;
    if (flashPgm_ff) begin
      mem[flashAddr_ff[3:0]] <= flashWData_ff;
    end
    if (flashEraseAll_ff) begin
      foreach (mem[i]) begin
        mem[i] <= FLASH_BLANK;
      end
    end
    if (optLoad) begin
      optionNv <= optSet;
    end else if (optPgm_ff) begin
      optionNv <= optWData_ff;
    end
  end
endmodule : cfgdbg_flash_model

// ==== tb/cfgdbg_loader_tb.sv ====
// Self-checking bench for the option byte loader
`timescale 1ns/1ns
module cfgdbg_loader_tb
  import cfgdbg_pkg::*;
;
  localparam int PWM_CH = 6;
  logic clk_sys, rst = 1'h1, sfrWrEn = 1'h0, oscOffReq = 1'h0, oscOnReq = 1'h0;
  logic powerDown = 1'h0, cpuHalted = 1'h0, dbgAccReq = 1'h0, rstPinIn = 1'h1;
  logic pin00In = 1'h1, pin01In = 1'h0, gpio00Out = 1'h0, gpio00OeN = 1'h0;
  logic gpio01Out = 1'h0, gpio01OeN = 1'h0, dbgDataOut = 1'h0, dbgDataOeN = 1'h1;
  logic optLoad = 1'h1, coreSwReset_ff, debugActive_ff, fastOscEn_ff, dbgAccGrant_ff;
  logic dbgAccReject_ff, extResetReq_ff, p12In_ff, pin00Out_ff, pin00OeN_ff, pin01Out_ff;
  logic pin01OeN_ff, gpio00In_ff, gpio01In_ff, dbgDataIn_ff, dbgClkIn_ff, extAck_ff;
  logic extOk_ff, iapAck_ff, flashRdEn_ff, flashPgm_ff, flashEraseAll_ff, optPgm_ff;
  logic [OPT_W-1:0]  sfrWData = 8'h00, optSet = 8'h6F, rdBack, optionNv, flashRData;
  logic [OPT_W-1:0]  chipCtrl_ff, extRData_ff, iapRData_ff, flashWData_ff, optWData_ff;
  logic [PWM_CH-1:0] pwmIn = 6'h15, pwmPinOutEn = 6'h0F, pwmPinOut_ff, pwmPinOeN_ff;
  logic [ADDR_W-1:0] flashAddr_ff;
  cfgdbg_req_t       extReq = '0, iapReq = '0;
  int                miscompares = 0, samples_checked = 0, cycles = 0;

  cfgdbg_loader #(.PWM_CH(PWM_CH)) u_dut (.*);
  cfgdbg_flash_model u_flash (.*);

  initial begin
    clk_sys = 1'h0;
    forever #4 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      miscompares++;
      close_out();
    end
  end

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic do_reset(input logic [7:0] opt);
    @(posedge clk_sys);
    rst <= 1'h1;
    optLoad <= 1'h1;
    optSet <= opt;
    repeat (8) @(posedge clk_sys);
    rst <= 1'h0;
    optLoad <= 1'h0;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : do_reset

  task automatic acc(input bit viaIap, input cfgdbg_cmd_t cmd, input logic [15:0] a,
                     input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    if (viaIap) iapReq <= '{1'h1, cmd, a, d};
    else extReq <= '{1'h1, cmd, a, d};
    do begin
      @(negedge clk_sys);
      n++;
    end while ((viaIap ? iapAck_ff : extAck_ff) !== 1'h1 && n < 20);
    if (n >= 20) chk("ack", 8'h00, 8'h01);
    rdBack = viaIap ? iapRData_ff : extRData_ff;
    @(posedge clk_sys);
    iapReq.req <= 1'h0;
    extReq.req <= 1'h0;
    repeat (2) @(posedge clk_sys);
  endtask : acc

  task automatic sfr(input logic [7:0] d);
    @(posedge clk_sys);
    sfrWrEn <= 1'h1;
    sfrWData <= d;
    @(posedge clk_sys);
    sfrWrEn <= 1'h0;
    @(negedge clk_sys);
  endtask : sfr

  // one debugger access request, checking grant and reject against expGrant
  task automatic dbg(input logic expGrant);
    @(posedge clk_sys);
    dbgAccReq <= 1'h1;
    @(posedge clk_sys);
    dbgAccReq <= 1'h0;
    @(negedge clk_sys);
    chk("grant", dbgAccGrant_ff, expGrant);
    chk("reject", dbgAccReject_ff, !expGrant);
  endtask : dbg

  task automatic close_out();
    $display("compared %0d, mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    do_reset(8'h6F);
    chk("ctrl", chipCtrl_ff, 8'h00);
    chk("debug", debugActive_ff, 1'h1);
    chk("clock pin oe", pin01OeN_ff, 1'h1);
    chk("data pin oe", pin00OeN_ff, 1'h1);
    @(posedge clk_sys);
    oscOffReq <= 1'h1;
    powerDown <= 1'h1;
    @(posedge clk_sys);
    oscOffReq <= 1'h0;
    repeat (3) @(posedge clk_sys);
    powerDown <= 1'h0;
    @(negedge clk_sys);
    chk("osc", fastOscEn_ff, 1'h1);
    dbg(1'h0);
    @(posedge clk_sys);
    cpuHalted <= 1'h1;
    dbg(1'h1);
    repeat (3) @(negedge clk_sys);
    chk("pwm float", pwmPinOeN_ff, 6'h3F);
    @(posedge clk_sys);
    cpuHalted <= 1'h0;
    repeat (3) @(negedge clk_sys);
    chk("pwm oe", pwmPinOeN_ff, 6'h30);
    chk("pwm out", pwmPinOut_ff & 6'h0F, 6'h05);
    acc(0, CMD_RD_FLASH, 16'h0003, 8'h00);
    chk("read", rdBack, 8'hA6);
    sfr(8'h83);
    chk("sw reset", coreSwReset_ff, 1'h1);
    repeat (3) @(negedge clk_sys);
    chk("ctrl", chipCtrl_ff, 8'h03);
    acc(0, CMD_PG_OPT, 16'h0000, 8'h80);
    chk("option", optionNv, 8'h49);
    do_reset(8'h49);
    chk("ctrl", chipCtrl_ff, 8'h00);
    chk("debug", debugActive_ff, 1'h0);
    @(posedge clk_sys);
    rstPinIn <= 1'h0;
    repeat (5) @(negedge clk_sys);
    chk("ext reset", extResetReq_ff, 1'h0);
    chk("plain in", p12In_ff, 1'h0);
    @(posedge clk_sys);
    oscOffReq <= 1'h1;
    @(posedge clk_sys);
    oscOffReq <= 1'h0;
    @(negedge clk_sys);
    chk("osc off", fastOscEn_ff, 1'h0);
    @(posedge clk_sys);
    oscOnReq <= 1'h1;
    @(posedge clk_sys);
    oscOnReq <= 1'h0;
    @(negedge clk_sys);
    chk("osc on", fastOscEn_ff, 1'h1);
    acc(0, CMD_RD_FLASH, 16'h0003, 8'h00);
    chk("locked read", rdBack, 8'hFF);
    acc(0, CMD_PG_FLASH, 16'h0003, 8'h11);
    chk("locked prog", extOk_ff, 1'h0);
    acc(0, CMD_PG_OPT, 16'h0000, 8'hFF);
    chk("locked opt", optionNv, 8'h49);
    acc(0, CMD_RD_OPT, 16'h0000, 8'h00);
    chk("opt read", rdBack, 8'h49);
    sfr(8'h01);
    acc(1, CMD_PG_FLASH, 16'h0005, 8'h3C);
    acc(1, CMD_RD_FLASH, 16'h0005, 8'h00);
    chk("self prog", rdBack, 8'h3C);
    acc(0, CMD_CHIP_ERASE, 16'h0000, 8'h00);
    chk("erased opt", optionNv, 8'hFF);
    acc(0, CMD_RD_FLASH, 16'h0005, 8'h00);
    chk("erased data", rdBack, 8'hFF);
    do_reset(8'hFF);
    chk("boot app", chipCtrl_ff, 8'h02);
    repeat (3) @(negedge clk_sys);
    chk("ext reset", extResetReq_ff, 1'h1);
    chk("plain in", p12In_ff, 1'h1);
    close_out();
  end
endmodule : cfgdbg_loader_tb
